// >>> core/vfp_stages.sv
// vfp_stages: definite-time voltage and frequency protection stages
// assumes measured values arrive from same-clock logic and the
// external block pin is asynchronous; registers sit on apb
//
// Functional notes
// - three undervoltage stages, own threshold and time, definite time
// - undervoltage starts when voltage falls below; trips after time
// - first undervoltage timer clears only after hold time without fault
// - fault returning within hold time resumes timing from kept value
// - external block pin inhibits undervoltage stages
// - selectable internal block signals inhibit undervoltage stages
// - all undervoltage blocked when all voltages below self-block level
// - measured value is max line voltage; thresholds in percent
// - hold time and hysteresis only on first undervoltage stage
// - each stage counts starts and trips, readable
// - two residual stages on fundamental residual voltage
// - residual starts above threshold, trips after time
// - phase mode uses computed residual, transformer secondary ref
// - line plus residual mode uses broken-delta, residual ref
// - line mode disables both residual stages
// - only lower residual stage has hold time
// - two frequency stages, each over or under
// - overfrequency starts above setting, trips after time
// - frequency source follows measurement mode
// - underfrequency starts below setting, trips after time
// - blocked stage shows no start, its timer freezes
`timescale 1ns/1ps
module vfp_stages #(
  parameter int TICK = vfp_pkg::TICK_CYC,
  parameter int TW = 16,
  parameter int CW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire vfp_pkg::vfp_meas_t meas,
  input wire logic ext_block_pin,
  input wire logic [3:0] int_block,
  output logic [vfp_pkg::NST-1:0] start,
  output logic [vfp_pkg::NST-1:0] trip
);
  localparam int N = vfp_pkg::NST;
  // refuse parameter values the timers and counter words cannot hold
  if (TICK < 2 || TW < 8 || TW > 16 || CW < 2 || CW > 16) begin : g_bad
    $error("vfp_stages: unsupported parameter values");
  end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl, rated, refs, uvth, resth, fth, hold;
  logic [15:0] top [N];
  logic [CW-1:0] scnt [N];
  logic [CW-1:0] tcnt [N];
  logic wr_en, rd_hit;
  logic [31:0] rd_val;
  assign wr_en = psel && penable && pready && pwrite;
  // read decode, unmapped addresses flag an error
  always_comb begin
    rd_val = 32'h0;
    rd_hit = 1'b1;
    if (paddr >= vfp_pkg::A_TOP && paddr < vfp_pkg::A_HOLD) begin
      rd_val = {16'h0, top[3'((paddr - vfp_pkg::A_TOP) >> 2)]};
    end else if (paddr >= vfp_pkg::A_CNT &&
        paddr < vfp_pkg::A_CNT + 8'(4 * N)) begin
      rd_val[CW-1:0] = scnt[3'((paddr - vfp_pkg::A_CNT) >> 2)];
      rd_val[16 +: CW] = tcnt[3'((paddr - vfp_pkg::A_CNT) >> 2)];
    end else begin
      unique case (paddr)
        vfp_pkg::A_CTRL: rd_val = ctrl;
        vfp_pkg::A_RATED: rd_val = rated;
        vfp_pkg::A_REFS: rd_val = refs;
        vfp_pkg::A_UVTH: rd_val = uvth;
        vfp_pkg::A_RESTH: rd_val = resth;
        vfp_pkg::A_FTH: rd_val = fth;
        vfp_pkg::A_HOLD: rd_val = hold;
        vfp_pkg::A_STAT: rd_val = {16'h0, 1'b0, trip, 1'b0, start};
        default: rd_hit = 1'b0;
      endcase
    end
    if (paddr[1:0] != 2'b00) begin
      rd_hit = 1'b0;
    end
  end
  // apb answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !rd_hit;
      if (psel && penable && !pready) begin
        prdata <= (pwrite || !rd_hit) ? 32'h0 : rd_val; // refused: no data
      end
    end
  end
  // software-written settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= vfp_pkg::RST_CTRL;
      rated <= vfp_pkg::RST_RATED;
      refs <= vfp_pkg::RST_REFS;
      uvth <= vfp_pkg::RST_UVTH;
      resth <= vfp_pkg::RST_RESTH;
      fth <= vfp_pkg::RST_FTH;
      hold <= vfp_pkg::RST_HOLD;
      for (int i = 0; i < N; i++) begin
        top[i] <= vfp_pkg::RST_TOP;
      end
    end else if (wr_en && !pslverr && rd_hit) begin
      if (paddr >= vfp_pkg::A_TOP && paddr < vfp_pkg::A_HOLD) begin
        top[3'((paddr - vfp_pkg::A_TOP) >> 2)] <= pwdata[15:0];
      end
      unique case (paddr)
        vfp_pkg::A_CTRL: ctrl <= {24'h0, pwdata[7:0]};
        vfp_pkg::A_RATED: rated <= {16'h0, pwdata[15:0]};
        vfp_pkg::A_REFS: refs <= pwdata;
        vfp_pkg::A_UVTH: uvth <= pwdata;
        vfp_pkg::A_RESTH: resth <= {8'h0, pwdata[23:0]};
        vfp_pkg::A_FTH: fth <= pwdata;
        vfp_pkg::A_HOLD: hold <= pwdata;
        default: ;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // inputs and time base
  // ----------------------------------------------------------------
  logic blk_s1, blk_s2;
  // the block pin is asynchronous: two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_s1 <= 1'b0;
      blk_s2 <= 1'b0;
    end else begin
      blk_s1 <= ext_block_pin;
      blk_s2 <= blk_s1;
    end
  end
  logic [$clog2(TICK)-1:0] div;
  logic tick;
  // one-cycle timer enable every TICK cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (div == '0);
      div <= (div == '0) ? ($clog2(TICK))'(TICK - 1) : div - 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // comparisons
  // ----------------------------------------------------------------
  vfp_pkg::vfp_mode_t mode;
  logic [15:0] umax, res, rref, fval;
  logic [31:0] un, uv_lhs, res_lhs;
  logic self_blk, uv_blk, res_off;
  logic [N-1:0] fault, blk;
  assign mode = vfp_pkg::vfp_mode_t'(ctrl[vfp_pkg::CTRL_MODE +: 2]);
  assign un = rated;
  // largest line voltage is the undervoltage measure
  always_comb begin
    umax = meas.u12;
    if (meas.u23 > umax) begin
      umax = meas.u23;
    end
    if (meas.u31 > umax) begin
      umax = meas.u31;
    end
  end
  assign uv_lhs = {16'h0, umax} * vfp_pkg::PCT;
  // self block when even the largest voltage is below the level
  assign self_blk = uv_lhs < uvth[31:24] * un;
  assign uv_blk = blk_s2 || self_blk ||
    (|(int_block & ctrl[vfp_pkg::CTRL_IBEN +: 4]));
  // residual source and scaling follow the measurement mode
  always_comb begin
    res = meas.res_calc;
    rref = refs[15:0];
    fval = meas.f_phase;
    if (mode != vfp_pkg::VM_PHASE) begin
      res = meas.res_meas;
      rref = refs[31:16];
      fval = meas.f_line;
    end
  end
  assign res_off = (mode == vfp_pkg::VM_LINE);
  assign res_lhs = {16'h0, res} * vfp_pkg::PCT;
  // fault conditions per stage
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      fault[i] = uv_lhs < uvth[8*i +: 8] * un;
      blk[i] = uv_blk;
    end
    // deadband widens the release level of the first stage
    if (start[0]) begin
      fault[0] = uv_lhs < (uvth[7:0] + resth[23:16]) * un;
    end
    for (int i = 0; i < 2; i++) begin
      fault[3+i] = res_lhs > resth[8*i +: 8] * rref;
      blk[3+i] = res_off;
      fault[5+i] = ctrl[vfp_pkg::CTRL_FUNDER+i] ?
        (fval < fth[16*i +: 16]) : (fval > fth[16*i +: 16]);
      blk[5+i] = 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // stage timers, outputs and counters
  // ----------------------------------------------------------------
  logic [TW-1:0] el [N];
  logic [15:0] mem [N];
  for (genvar g = 0; g < N; g++) begin : g_st
    localparam bit HASH = (g == 0) || (g == 3);
    logic [15:0] ht;
    logic clr;
    assign ht = (g == 0) ? hold[15:0] : hold[31:16];
    // without hold time the timer clears at once on release
    assign clr = !HASH || (mem[g] >= ht);
    // elapsed time: frozen while blocked, kept while released within hold time
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        el[g] <= '0;
        mem[g] <= 16'h0;
      end else if (blk[g]) begin
        mem[g] <= mem[g];
      end else if (fault[g]) begin
        mem[g] <= 16'h0;
        if (tick && el[g] < top[g][TW-1:0]) begin
          el[g] <= el[g] + 1'b1;
        end
      end else if (clr) begin
        el[g] <= '0;
        mem[g] <= 16'h0;
      end else if (tick) begin
        mem[g] <= mem[g] + 16'h1;
      end
    end
    // start and trip are levels that follow the condition
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        start[g] <= 1'b0;
        trip[g] <= 1'b0;
      end else begin
        start[g] <= fault[g] && !blk[g];
        trip[g] <= fault[g] && !blk[g] && el[g] >= top[g][TW-1:0];
      end
    end
    // counters step on the rising edge of start and trip
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        scnt[g] <= '0;
        tcnt[g] <= '0;
      end else begin
        if (fault[g] && !blk[g] && !start[g]) begin
          scnt[g] <= scnt[g] + 1'b1;
        end
        if (fault[g] && !blk[g] && el[g] >= top[g][TW-1:0] && !trip[g])
        begin
          tcnt[g] <= tcnt[g] + 1'b1;
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_uv_blocked;
    @(posedge pclk) disable iff (!presetn)
    uv_blk |=> start[2:0] == 3'b000 && trip[2:0] == 3'b000;
  endproperty
  a_uv_blocked: assert property (p_uv_blocked)
    else $error("undervoltage active while blocked");
  property p_self_blk;
    @(posedge pclk) disable iff (!presetn)
    self_blk |=> !start[0] && !start[1];
  endproperty
  a_self_blk: assert property (p_self_blk)
    else $error("self block ignored");
  property p_res_off;
    @(posedge pclk) disable iff (!presetn)
    mode == vfp_pkg::VM_LINE |=> start[4:3] == 2'b00;
  endproperty
  a_res_off: assert property (p_res_off)
    else $error("residual active in line mode");
  property p_uv_start;
    @(posedge pclk) disable iff (!presetn)
    fault[1] && !uv_blk |=> start[1];
  endproperty
  a_uv_start: assert property (p_uv_start)
    else $error("undervoltage start missing");
  property p_under_f;
    @(posedge pclk) disable iff (!presetn)
    ctrl[vfp_pkg::CTRL_FUNDER+1] && fval < fth[31:16] |=> start[6];
  endproperty
  a_under_f: assert property (p_under_f)
    else $error("underfrequency start missing");
  property p_trip_start;
    @(posedge pclk) disable iff (!presetn)
    $rose(trip[5]) |-> start[5] && el[5] >= top[5][TW-1:0];
  endproperty
  a_trip_start: assert property (p_trip_start)
    else $error("trip without start or time");
  property p_scnt;
    @(posedge pclk) disable iff (!presetn)
    $rose(start[0]) |-> scnt[0] == CW'($past(scnt[0]) + 1'b1);
  endproperty
  a_scnt: assert property (p_scnt)
    else $error("start counter did not step");
  property p_tcnt;
    @(posedge pclk) disable iff (!presetn)
    !$rose(trip[3]) |-> tcnt[3] == $past(tcnt[3]);
  endproperty
  a_tcnt: assert property (p_tcnt)
    else $error("trip counter stepped without trip edge");
  property p_no_hold;
    @(posedge pclk) disable iff (!presetn)
    !fault[2] && !uv_blk |=> el[2] == '0;
  endproperty
  a_no_hold: assert property (p_no_hold)
    else $error("timer kept on stage without hold");
  property p_freeze;
    @(posedge pclk) disable iff (!presetn)
    uv_blk ##1 uv_blk |-> el[0] == $past(el[0]);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("timer moved while blocked");
  property p_res_start;
    @(posedge pclk) disable iff (!presetn)
    fault[4] && !res_off |=> start[4];
  endproperty
  a_res_start: assert property (p_res_start)
    else $error("residual start missing");
  property p_over_f;
    @(posedge pclk) disable iff (!presetn)
    !ctrl[vfp_pkg::CTRL_FUNDER] && fval > fth[15:0] |=> start[5];
  endproperty
  a_over_f: assert property (p_over_f)
    else $error("overfrequency start missing");
  property p_level_drop;
    @(posedge pclk) disable iff (!presetn)
    !fault[1] |=> !start[1] && !trip[1];
  endproperty
  a_level_drop: assert property (p_level_drop)
    else $error("start or trip kept after fault cleared");
  property p_hold_keep;
    @(posedge pclk) disable iff (!presetn)
    !fault[0] && !uv_blk && mem[0] < hold[15:0] |=> el[0] == $past(el[0]);
  endproperty
  a_hold_keep: assert property (p_hold_keep)
    else $error("timer cleared inside hold time");
  property p_resume;
    @(posedge pclk) disable iff (!presetn)
    fault[0] && !uv_blk && tick && el[0] < top[0][TW-1:0] |=>
      el[0] == TW'($past(el[0]) + 1'b1);
  endproperty
  a_resume: assert property (p_resume)
    else $error("timer did not advance from kept value");
  property p_tick_pulse;
    @(posedge pclk) disable iff (!presetn)
    tick |=> !tick;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse)
    else $error("timer enable longer than one cycle");
  property p_res_direct;
    @(posedge pclk) disable iff (!presetn)
    mode == vfp_pkg::VM_LINE_PLUS_RESIDUAL &&
      32'(meas.res_meas) * vfp_pkg::PCT > resth[7:0] * refs[31:16]
      |=> start[3];
  endproperty
  a_res_direct: assert property (p_res_direct)
    else $error("measured residual not used in line plus residual mode");
endmodule

// >>> core/vfp_pkg.sv
// vfp_pkg: constants, types and register map of the protection stages
// assumes a 200 MHz pclk and a 32-bit apb register bus
package vfp_pkg;
  // ----------------------------------------------------------------
  // stages and timing
  // ----------------------------------------------------------------
  localparam int NST = 7; // 0..2 undervoltage, 3..4 residual, 5..6 freq
  localparam int CLK_NS = 5;
  localparam int TICK_US = 10000; // timer resolution 10 ms
  localparam int TICK_CYC = TICK_US * 1000 / CLK_NS;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_RATED = 8'h04;
  localparam logic [7:0] A_REFS = 8'h08;
  localparam logic [7:0] A_UVTH = 8'h0c;
  localparam logic [7:0] A_RESTH = 8'h10;
  localparam logic [7:0] A_FTH = 8'h14;
  localparam logic [7:0] A_TOP = 8'h18; // 7 words, one per stage
  localparam logic [7:0] A_HOLD = 8'h34;
  localparam logic [7:0] A_STAT = 8'h38;
  localparam logic [7:0] A_CNT = 8'h3c; // 7 words, one per stage
  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_MODE = 0; // [1:0]
  localparam int CTRL_FUNDER = 2; // [3:2] 1 = underfrequency
  localparam int CTRL_IBEN = 4; // [7:4] internal block enables
  localparam logic [31:0] RST_CTRL = 32'h0000_0001;
  localparam logic [31:0] RST_RATED = 32'h0000_2710;
  localparam logic [31:0] RST_REFS = 32'h0064_0064;
  localparam logic [31:0] RST_UVTH = 32'h0000_0000;
  localparam logic [31:0] RST_RESTH = 32'h0000_6464;
  localparam logic [31:0] RST_FTH = 32'hffff_ffff;
  localparam logic [15:0] RST_TOP = 16'h000a;
  localparam logic [31:0] RST_HOLD = 32'h0000_0000;
  localparam logic [31:0] PCT = 32'h0000_0064; // 100 percent
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    VM_PHASE,
    VM_LINE,
    VM_LINE_PLUS_RESIDUAL
  } vfp_mode_t;
  // measured values from the front end, same clock
  typedef struct packed {
    logic [15:0] u12;
    logic [15:0] u23;
    logic [15:0] u31;
    logic [15:0] res_calc; // from phase voltages
    logic [15:0] res_meas; // broken-delta input
    logic [15:0] f_phase;
    logic [15:0] f_line;
  } vfp_meas_t;
endpackage

// >>> verif/vfp_front.sv
// vfp_front: measurement front end model feeding the stages
// assumes the bench sets plain levels; samples launch on pclk
`timescale 1ns/1ps
module vfp_front (
  input wire logic pclk,
  input wire logic [15:0] ul,
  input wire logic [15:0] rc,
  input wire logic [15:0] rm,
  input wire logic [15:0] fp,
  input wire logic [15:0] fl,
  output vfp_pkg::vfp_meas_t meas
);
  // --------------------
  // registered samples
  // --------------------
  // u23 carries the highest line value, the others lower
  always @(posedge pclk) begin
    meas.u12 <= ul >> 2;
    meas.u23 <= ul;
    meas.u31 <= ul >> 1;
    meas.res_calc <= rc;
    meas.res_meas <= rm;
    meas.f_phase <= fp;
    meas.f_line <= fl;
  end
endmodule

// >>> verif/vfp_stages_tb.sv
// vfp_stages_tb: self-checking bench for the protection stages
// assumes vfp_front feeds measurements and the tick is cut to 10 cycles
`timescale 1ns/1ps
module vfp_stages_tb;
  localparam int TK = 10;
  localparam int REF = 100; // secondary refs keep their reset value
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic ext_block_pin, rd_e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [3:0] int_block, iben;
  logic [6:0] start, trip, pe, ee;
  logic [15:0] ul, rc, rm, fp, fl;
  logic [1:0] mode, und;
  vfp_pkg::vfp_meas_t meas;
  int th[3], sb, rlo, rhi, f1, f2, scnt[7], tcnt[7];
  int errors, compares, seed, n;
  logic [7:0] ra [9] = '{vfp_pkg::A_CTRL, vfp_pkg::A_RATED,
    vfp_pkg::A_REFS, vfp_pkg::A_UVTH, vfp_pkg::A_RESTH, vfp_pkg::A_FTH,
    vfp_pkg::A_TOP, vfp_pkg::A_HOLD, vfp_pkg::A_STAT};
  logic [31:0] rv [9] = '{vfp_pkg::RST_CTRL, vfp_pkg::RST_RATED,
    vfp_pkg::RST_REFS, vfp_pkg::RST_UVTH, vfp_pkg::RST_RESTH,
    vfp_pkg::RST_FTH, {16'h0000, vfp_pkg::RST_TOP}, vfp_pkg::RST_HOLD,
    32'h0000_0000};

  vfp_stages #(.TICK(TK)) vfp_stages_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas(meas), .ext_block_pin(ext_block_pin), .int_block(int_block),
    .start(start), .trip(trip));
  vfp_front vfp_front_inst (.pclk(pclk), .ul(ul), .rc(rc), .rm(rm),
    .fp(fp), .fl(fl), .meas(meas));

  // --------------------
  // clock, model, reports
  // --------------------
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // expected start levels from the measured values and settings
  function automatic logic [6:0] exp_start(vfp_pkg::vfp_meas_t m);
    int mx, r, f;
    logic blk;
    logic [6:0] e;
    mx = m.u12;
    if (m.u23 > mx) mx = m.u23;
    if (m.u31 > mx) mx = m.u31;
    blk = ext_block_pin | (|(iben & int_block)) | (mx * 100 < sb * 10000);
    for (int i = 0; i < 3; i++) e[i] = !blk && mx * 100 < th[i] * 10000;
    r = (mode == 2'd0) ? m.res_calc : m.res_meas;
    e[3] = mode != 2'd1 && r * 100 > rlo * REF;
    e[4] = mode != 2'd1 && r * 100 > rhi * REF;
    f = (mode == 2'd0) ? m.f_phase : m.f_line;
    e[5] = und[0] ? f < f1 : f > f1;
    e[6] = und[1] ? f < f2 : f > f2;
    return e;
  endfunction

  // model start counters step on each expected rise
  always @(posedge pclk) begin
    if (presetn === 1'b1) begin
      ee = exp_start(meas);
      for (int i = 0; i < 7; i++) if (ee[i] && !pe[i]) scnt[i]++;
      pe = ee;
    end
  end

  task automatic check(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // drive measurements, let them settle, compare start levels
  task automatic put(input int u, input int a, input int b, input int p,
    input int q);
    @(posedge pclk);
    ul <= u[15:0];
    rc <= a[15:0];
    rm <= b[15:0];
    fp <= p[15:0];
    fl <= q[15:0];
    repeat (5) @(posedge pclk);
    @(negedge pclk);
    check("start", {25'h0, start}, {25'h0, exp_start(meas)});
  endtask

  task automatic wait_trip();
    n = 0;
    while (trip[0] !== 1'b1 && n < 200) begin
      @(negedge pclk);
      n++;
    end
  endtask

  // --------------------
  // main sequence
  // --------------------
  initial begin
    {psel, penable, pwrite, ext_block_pin, presetn} = 5'b0;
    {paddr, pwdata, int_block, iben, rc, rm} = '0;
    {ul, fp, fl} = {16'h2710, 16'h1324, 16'h1324};
    {th[0], th[1], th[2], sb} = {32'h0, 32'h0, 32'h0, 32'h0};
    {rlo, rhi, f1, f2} = {32'h64, 32'h64, 32'hffff, 32'hffff};
    {mode, und} = 4'h4;
    seed = 72;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      apb(1'b0, ra[k], 32'h0);
      check("reset value", rd_v, rv[k]);
    end
    for (int k = 0; k < 2; k++) begin
      apb(1'b0, k ? 8'h02 : 8'h80, 32'h0);
      check("slverr", {31'h0, rd_e}, 32'h1);
      check("err rdata", rd_v, 32'h0);
    end
    apb(1'b1, vfp_pkg::A_STAT, 32'hffff_ffff);
    apb(1'b0, vfp_pkg::A_STAT, 32'h0);
    check("status", rd_v, 32'h0);
    apb(1'b1, vfp_pkg::A_TOP, 32'h4);
    for (int i = 1; i < 7; i++) apb(1'b1, vfp_pkg::A_TOP + 8'(4 * i), 1000);
    apb(1'b1, vfp_pkg::A_CTRL, 32'h9);
    und = 2'b10;
    apb(1'b1, vfp_pkg::A_FTH, 32'h12c0_1388);
    {f1, f2} = {32'h1388, 32'h12c0};
    apb(1'b1, vfp_pkg::A_UVTH, 32'h0a3c_4650);
    {th[0], th[1], th[2], sb} = {32'h50, 32'h46, 32'h3c, 32'ha};
    apb(1'b1, vfp_pkg::A_RESTH, 32'h0000_5032);
    {rlo, rhi} = {32'h32, 32'h50};
    apb(1'b1, vfp_pkg::A_HOLD, 32'h5);
    // first undervoltage stage: trip time, hold memory, block freeze
    @(posedge pclk) ul <= 16'd7500;
    wait_trip();
    check("trip time", n >= 28 && n <= 55, 1);
    put(10000, 0, 0, 4900, 4900);
    check("trip clear", trip, 0);
    repeat (80) @(posedge pclk);
    put(7500, 0, 0, 4900, 4900);
    repeat (24) @(posedge pclk);
    check("timer cleared", trip, 0);
    @(posedge pclk) ul <= 16'd10000;
    repeat (20) @(posedge pclk);
    ul <= 16'd7500;
    wait_trip();
    check("resume", n <= 24, 1);
    put(10000, 0, 0, 4900, 4900);
    repeat (80) @(posedge pclk);
    ul <= 16'd7500;
    repeat (15) @(posedge pclk);
    ext_block_pin <= 1'b1;
    repeat (150) @(posedge pclk);
    check("blocked", {start[0], trip[0]}, 0);
    ext_block_pin <= 1'b0;
    wait_trip();
    check("frozen timer", n >= 15 && n <= 36, 1);
    put(10000, 0, 0, 4900, 4900);
    tcnt[0] = 3;
    repeat (80) @(posedge pclk);
    // internal blocking through enabled sources only
    apb(1'b1, vfp_pkg::A_CTRL, 32'h59);
    iben = 4'b0101;
    for (int k = 0; k < 4; k++) begin
      @(posedge pclk) int_block <= 4'(1 << k);
      put(7500, 0, 0, 4900, 4900);
      put(10000, 0, 0, 4900, 4900);
    end
    int_block <= 4'h0;
    repeat (80) @(posedge pclk);
    put(500, 0, 0, 4900, 4900);
    put(1500, 0, 0, 4900, 4900);
    put(10000, 0, 0, 4900, 4900);
    repeat (80) @(posedge pclk);
    // residual and frequency stages in every measurement mode
    iben = 4'h0;
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, vfp_pkg::A_CTRL, 32'h8 | m);
      mode = 2'(m);
      repeat (6) put(10000, $random(seed) & 127, $random(seed) & 127,
        4700 + ($random(seed) & 511), 4700 + ($random(seed) & 511));
    end
    put(10000, 0, 0, 4900, 4900);
    // residual and frequency trips with short operating times
    for (int i = 3; i < 7; i++) apb(1'b1, vfp_pkg::A_TOP + 8'(4 * i), 2);
    put(10000, 0, 100, 4900, 5100);
    repeat (30) @(negedge pclk);
    check("trip", trip[6:3], 4'h7);
    put(10000, 0, 0, 4900, 4700);
    repeat (30) @(negedge pclk);
    check("trip", trip[6:3], 4'h8);
    put(10000, 0, 0, 4900, 4900);
    for (int i = 3; i < 7; i++) tcnt[i] = 1;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, vfp_pkg::A_CNT + 8'(4 * i), 32'h0);
      check("counts", rd_v, {tcnt[i][15:0], scnt[i][15:0]});
    end
    conclude();
  end

  // watchdog for a hung handshake or wait
  initial begin
    #400000;
    errors++;
    conclude();
  end
endmodule
